// >>> rtl/csfa_top.sv
// Condition register, operation sequencing and operand checks.
module csfa_top import csfa_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire csfa_op_e op,
    input wire logic [7:0] dst_value,
    input wire logic [7:0] src_value,
    input wire logic [7:0] dst_addr,
    input wire logic load_valid,
    input wire logic [7:0] load_addr,
    input wire logic [7:0] load_data,
    input wire logic [7:0] pair_addr,
    input wire logic [3:0] work_pair,
    input wire logic [15:0] pair_value,
    input wire logic [7:0] disp,
    input wire logic [15:0] next_pc,
    input wire logic [15:0] direct_addr,
    output logic [7:0] cpu_condition_register,
    output logic [3:0] branch_flags,
    output logic [7:0] result,
    output logic result_we,
    output logic done,
    output logic dest_conflict,
    output logic pair_ok,
    output logic work_pair_ok,
    output logic direct_ok,
    output logic [15:0] short_index_addr,
    output logic [15:0] branch_target
);
    csfa_state_e state;
    csfa_state_e next_state;
    logic [7:0] next_flags;
    logic [7:0] next_result;
    logic next_result_we;
    logic next_conflict;
    logic [7:0] alu_result;
    logic alu_we;
    logic [3:0] alu_flags;
    logic [3:0] alu_mask;
    logic [7:0] merged;
    csfa_alu u_alu (
        .op(op),
        .dst(dst_value),
        .src(src_value),
        .carry_in(cpu_condition_register[CSFA_BIT_C]),
        .result(alu_result),
        .write_result(alu_we),
        .flags_new(alu_flags),
        .flags_mask(alu_mask)
    );
    csfa_addr u_addr (
        .reg_addr(dst_addr),
        .pair_addr(pair_addr),
        .work_pair(work_pair),
        .pair_value(pair_value),
        .disp(disp),
        .next_pc(next_pc),
        .direct_addr(direct_addr),
        .pair_ok(pair_ok),
        .work_pair_ok(work_pair_ok),
        .direct_ok(direct_ok),
        .short_index_addr(short_index_addr),
        .branch_target(branch_target)
    );
    assign branch_flags = cpu_condition_register[CSFA_BIT_C:CSFA_BIT_V];
    always_comb begin
        merged = cpu_condition_register;
        merged[7:4] = (alu_flags & alu_mask) | (cpu_condition_register[7:4] & ~alu_mask);
        next_flags = cpu_condition_register;
        next_result = result;
        next_result_we = 1'b0;
        next_conflict = 1'b0;
        next_state = CSFA_ST_IDLE;
        case (state)
            CSFA_ST_IDLE, CSFA_ST_DONE: begin
                if (op_valid && op != CSFA_OP_NONE) begin
                    // Low nibble never changes on an operation.
                    next_flags = merged;
                    next_result = alu_result;
                    next_result_we = alu_we;
                    // Result write to the flag register is flagged, and the flag update wins.
                    next_conflict = alu_we && (alu_mask != 4'h0) && (dst_addr == CSFA_FLAGS_ADDR);
                    if (alu_we && (alu_mask == 4'h0) && (dst_addr == CSFA_FLAGS_ADDR)) begin
                        next_flags = alu_result;
                    end
                    next_state = CSFA_ST_DONE;
                end else if (load_valid && load_addr == CSFA_FLAGS_ADDR) begin
                    next_flags = load_data;
                end
            end
            default: begin
                next_state = CSFA_ST_IDLE;
            end
        endcase
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= CSFA_ST_IDLE;
            cpu_condition_register <= CSFA_FLAGS_RESET;
            result <= 8'h00;
            result_we <= 1'b0;
            dest_conflict <= 1'b0;
        end else begin
            state <= next_state;
            cpu_condition_register <= next_flags;
            result <= next_result;
            result_we <= next_result_we;
            dest_conflict <= next_conflict;
        end
    end
    assign done = (state == CSFA_ST_DONE);
    a_logic_clears_v: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op inside {CSFA_OP_AND, CSFA_OP_OR, CSFA_OP_XOR}
        |=> !cpu_condition_register[CSFA_BIT_V])
        else $error("overflow not cleared after logic op");
    a_zero_tracks_result: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op inside {CSFA_OP_ADD, CSFA_OP_SUB, CSFA_OP_AND, CSFA_OP_XOR}
        |=> cpu_condition_register[CSFA_BIT_Z] == (result == 8'h00))
        else $error("zero flag does not match result");
    a_sign_tracks_msb: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op inside {CSFA_OP_ADD, CSFA_OP_OR, CSFA_OP_ROT_LEFT, CSFA_OP_ROT_RIGHT}
        |=> cpu_condition_register[CSFA_BIT_S] == result[7])
        else $error("sign flag does not match result msb");
    a_add_carry_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op == CSFA_OP_ADD
        |=> cpu_condition_register[CSFA_BIT_C] == ({1'b0, $past(dst_value)} + {1'b0, $past(src_value)} > 9'h0FF))
        else $error("add carry wrong");
    a_rlc_rotate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op == CSFA_OP_ROT_LEFT_CARRY
        |=> {cpu_condition_register[CSFA_BIT_C], result} == {$past(dst_value), $past(cpu_condition_register[CSFA_BIT_C])})
        else $error("rotate left through carry wrong");
    a_rrc_rotate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op == CSFA_OP_ROT_RIGHT_CARRY
        |=> {result, cpu_condition_register[CSFA_BIT_C]} == {$past(cpu_condition_register[CSFA_BIT_C]), $past(dst_value)})
        else $error("rotate right through carry wrong");
    a_carry_ops_only_c: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op inside {CSFA_OP_CARRY_SET, CSFA_OP_CARRY_CLEAR, CSFA_OP_CARRY_INVERT}
        |=> cpu_condition_register[6:0] == $past(cpu_condition_register[6:0]) && !result_we)
        else $error("carry op disturbed other bits");
    a_tcm_no_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op == CSFA_OP_INV_MASK_TEST
        |=> !result_we && cpu_condition_register[CSFA_BIT_Z] == ((~$past(dst_value) & $past(src_value)) == 8'h00))
        else $error("inverted mask test wrong");
    a_low_nibble_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
        op_valid && op != CSFA_OP_NONE && dst_addr != CSFA_FLAGS_ADDR
        |=> cpu_condition_register[3:0] == $past(cpu_condition_register[3:0]))
        else $error("low flag bits changed by operation");
    a_load_writes_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !op_valid && load_valid && load_addr == CSFA_FLAGS_ADDR
        |=> cpu_condition_register == $past(load_data))
        else $error("load to flag register lost");
endmodule

// >>> rtl/csfa_pkg.sv
// Shared constants for the status-flag and operand-range datapath.
// Operation
// - Eight-bit flag register; upper four feed branches.
// - Plain loads write the flag register directly.
// - AND updates zero, sign and overflow.
// - Overflow bit four marks signed range overflow.
// - Logical operations force overflow to zero.
// - Sign bit five copies result MSB.
// - Arithmetic and logic: zero when result zero.
// - Test, rotate, shift: zero when value zero.
// - Carry bit seven marks carry or borrow.
// - Rotate or shift carry holds last bit out.
// - Carry set, clear, invert touch only carry.
// - Rotate left through carry, nine bits.
// - Rotate right through carry, nine bits.
// - Inverted mask test updates flags, keeps destination.
// - Registers span 0-255, working registers 0-15.
// - Pairs even 0-254, working pairs even 0-14.
// - Direct program addresses span 0-8191.
// - Short indexed adds signed displacement to pair.
// - Relative target adds displacement to next address.
package csfa_pkg;
    localparam logic [7:0] CSFA_FLAGS_ADDR = 8'hD5;
    localparam logic [7:0] CSFA_FLAGS_RESET = 8'h00;
    localparam int CSFA_BIT_V = 4;
    localparam int CSFA_BIT_S = 5;
    localparam int CSFA_BIT_Z = 6;
    localparam int CSFA_BIT_C = 7;
    localparam int CSFA_PADDR_W = 13;
    localparam logic [7:0] CSFA_PAIR_MAX = 8'hFE;
    localparam logic [3:0] CSFA_WPAIR_MAX = 4'hE;
    typedef enum logic [4:0] {
        CSFA_OP_NONE = 5'h00, CSFA_OP_ADD = 5'h01, CSFA_OP_ADC = 5'h02,
        CSFA_OP_SUB = 5'h03, CSFA_OP_SBC = 5'h04, CSFA_OP_CMP = 5'h05,
        CSFA_OP_INC = 5'h06, CSFA_OP_DEC = 5'h07, CSFA_OP_AND = 5'h08,
        CSFA_OP_OR = 5'h09, CSFA_OP_XOR = 5'h0A, CSFA_OP_COM = 5'h0B,
        CSFA_OP_MASK_TEST = 5'h0C, CSFA_OP_INV_MASK_TEST = 5'h0D,
        CSFA_OP_ROT_LEFT = 5'h0E, CSFA_OP_ROT_LEFT_CARRY = 5'h0F,
        CSFA_OP_ROT_RIGHT = 5'h10, CSFA_OP_ROT_RIGHT_CARRY = 5'h11,
        CSFA_OP_ARITH_SHIFT_RIGHT = 5'h12, CSFA_OP_CARRY_SET = 5'h13,
        CSFA_OP_CARRY_CLEAR = 5'h14, CSFA_OP_CARRY_INVERT = 5'h15
    } csfa_op_e;
    typedef enum logic [1:0] {
        CSFA_ST_IDLE = 2'b01,
        CSFA_ST_DONE = 2'b10
    } csfa_state_e;
endpackage

// >>> rtl/csfa_alu.sv
// Combinational result and flag generation for one operation.
module csfa_alu import csfa_pkg::*; (
    input wire csfa_op_e op,
    input wire logic [7:0] dst,
    input wire logic [7:0] src,
    input wire logic carry_in,
    output logic [7:0] result,
    output logic write_result,
    output logic [3:0] flags_new,
    output logic [3:0] flags_mask
);
    logic [8:0] sum;
    logic c;
    logic z;
    logic s;
    logic v;
    logic [7:0] b;
    always_comb begin
        sum = 9'h000;
        b = 8'h00;
        result = dst;
        write_result = 1'b0;
        c = carry_in;
        v = 1'b0;
        flags_mask = 4'h0;
        case (op)
            CSFA_OP_ADD, CSFA_OP_ADC, CSFA_OP_INC: begin
                b = (op == CSFA_OP_INC) ? 8'h01 : src;
                sum = {1'b0, dst} + {1'b0, b} + {8'h00, op == CSFA_OP_ADC && carry_in};
                result = sum[7:0];
                write_result = 1'b1;
                c = sum[8];
                v = (dst[7] == b[7]) && (result[7] != dst[7]);
                flags_mask = (op == CSFA_OP_INC) ? 4'h7 : 4'hF;
            end
            CSFA_OP_SUB, CSFA_OP_SBC, CSFA_OP_CMP, CSFA_OP_DEC: begin
                b = (op == CSFA_OP_DEC) ? 8'h01 : src;
                sum = {1'b0, dst} - {1'b0, b} - {8'h00, op == CSFA_OP_SBC && carry_in};
                result = sum[7:0];
                write_result = (op != CSFA_OP_CMP);
                c = sum[8];
                v = (dst[7] != b[7]) && (result[7] != dst[7]);
                flags_mask = (op == CSFA_OP_DEC) ? 4'h7 : 4'hF;
            end
            CSFA_OP_AND, CSFA_OP_OR, CSFA_OP_XOR, CSFA_OP_COM: begin
                case (op)
                    CSFA_OP_AND: result = dst & src;
                    CSFA_OP_OR: result = dst | src;
                    CSFA_OP_XOR: result = dst ^ src;
                    default: result = ~dst;
                endcase
                write_result = 1'b1;
                v = 1'b0;
                flags_mask = 4'h7;
            end
            CSFA_OP_MASK_TEST, CSFA_OP_INV_MASK_TEST: begin
                // Destination is left alone; only flags change.
                result = (op == CSFA_OP_INV_MASK_TEST) ? (~dst & src) : (dst & src);
                v = 1'b0;
                flags_mask = 4'h7;
            end
            CSFA_OP_ROT_LEFT, CSFA_OP_ROT_LEFT_CARRY: begin
                result = {dst[6:0], (op == CSFA_OP_ROT_LEFT) ? dst[7] : carry_in};
                c = dst[7];
                v = dst[7] ^ dst[6];
                write_result = 1'b1;
                flags_mask = 4'hF;
            end
            CSFA_OP_ROT_RIGHT, CSFA_OP_ROT_RIGHT_CARRY, CSFA_OP_ARITH_SHIFT_RIGHT: begin
                case (op)
                    CSFA_OP_ROT_RIGHT: result = {dst[0], dst[7:1]};
                    CSFA_OP_ROT_RIGHT_CARRY: result = {carry_in, dst[7:1]};
                    default: result = {dst[7], dst[7:1]};
                endcase
                c = dst[0];
                v = (op == CSFA_OP_ARITH_SHIFT_RIGHT) ? 1'b0 : (dst[0] ^ dst[7]);
                write_result = 1'b1;
                flags_mask = 4'hF;
            end
            CSFA_OP_CARRY_SET: begin
                c = 1'b1;
                flags_mask = 4'h8;
            end
            CSFA_OP_CARRY_CLEAR: begin
                c = 1'b0;
                flags_mask = 4'h8;
            end
            CSFA_OP_CARRY_INVERT: begin
                c = ~carry_in;
                flags_mask = 4'h8;
            end
            default: begin
                result = dst;
            end
        endcase
        z = (result == 8'h00);
        s = result[7];
        flags_new = {c, z, s, v};
    end
endmodule

// >>> rtl/csfa_addr.sv
// Operand range checks and effective address arithmetic.
module csfa_addr import csfa_pkg::*; (
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] pair_addr,
    input wire logic [3:0] work_pair,
    input wire logic [15:0] pair_value,
    input wire logic [7:0] disp,
    input wire logic [15:0] next_pc,
    input wire logic [15:0] direct_addr,
    output logic pair_ok,
    output logic work_pair_ok,
    output logic direct_ok,
    output logic [15:0] short_index_addr,
    output logic [15:0] branch_target
);
    function automatic logic [15:0] csfa_add_disp(input logic [15:0] base, input logic [7:0] d);
        csfa_add_disp = base + {{8{d[7]}}, d};
    endfunction
    logic unused_reg;
    assign unused_reg = ^reg_addr; // any 8-bit value is a legal register
    assign pair_ok = !pair_addr[0] && (pair_addr <= CSFA_PAIR_MAX);
    assign work_pair_ok = !work_pair[0] && (work_pair <= CSFA_WPAIR_MAX);
    assign direct_ok = (direct_addr[15:CSFA_PADDR_W] == 3'h0);
    assign short_index_addr = csfa_add_disp(pair_value, disp);
    assign branch_target = csfa_add_disp(next_pc, disp);
endmodule

// >>> tb/csfa_seq_model.sv
// Sequencer model that issues operations and flag-register loads.
module csfa_seq_model import csfa_pkg::*; (
    input wire logic clk_sys,
    output logic op_valid,
    output csfa_op_e op,
    output logic [7:0] dst_value,
    output logic [7:0] src_value,
    output logic [7:0] dst_addr,
    output logic load_valid,
    output logic [7:0] load_addr,
    output logic [7:0] load_data
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        op_valid = 1'b0;
        op = CSFA_OP_NONE;
        dst_value = 8'h5C;
        src_value = 8'hA3;
        dst_addr = 8'h20;
        load_valid = 1'b0;
        load_addr = 8'h00;
        load_data = 8'h96;
    end

    // The request is left up on return, so back-to-back calls never lower and raise in one step.
    task automatic do_op(input csfa_op_e code, input logic [7:0] d, input logic [7:0] s,
                         input logic [7:0] a);
        op_valid = 1'b1;
        load_valid = 1'b0;
        op = code;
        dst_value = d;
        src_value = s;
        dst_addr = a;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic do_load(input logic [7:0] a, input logic [7:0] d);
        op_valid = 1'b0;
        load_valid = 1'b1;
        op = CSFA_OP_NONE;
        load_addr = a;
        load_data = d;
        @(posedge clk_sys);
        #1;
    endtask

    // Released operand lines flip so stale values cannot pass for live ones.
    task automatic idle();
        op_valid = 1'b0;
        load_valid = 1'b0;
        op = CSFA_OP_NONE;
        dst_value = ~dst_value;
        src_value = ~src_value;
        load_data = ~load_data;
    endtask
endmodule

// >>> tb/csfa_top_test.sv
// Self-checking bench for the status-flag and operand-range datapath.
module csfa_top_test import csfa_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys = 1'b0;
    logic rst_n;
    logic op_valid;
    csfa_op_e op;
    logic [7:0] dst_value;
    logic [7:0] src_value;
    logic [7:0] dst_addr;
    logic load_valid;
    logic [7:0] load_addr;
    logic [7:0] load_data;
    logic [7:0] pair_addr;
    logic [3:0] work_pair;
    logic [15:0] pair_value;
    logic [7:0] disp;
    logic [15:0] next_pc;
    logic [15:0] direct_addr;
    logic [7:0] cpu_condition_register;
    logic [3:0] branch_flags;
    logic [7:0] result;
    logic result_we;
    logic done;
    logic dest_conflict;
    logic pair_ok;
    logic work_pair_ok;
    logic direct_ok;
    logic [15:0] short_index_addr;
    logic [15:0] branch_target;
    int miscompares = 0;
    int cmp_count = 0;

    always #5 clk_sys = ~clk_sys;

    csfa_top i_csfa_top (.clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid), .op(op),
        .dst_value(dst_value), .src_value(src_value), .dst_addr(dst_addr),
        .load_valid(load_valid), .load_addr(load_addr), .load_data(load_data),
        .pair_addr(pair_addr), .work_pair(work_pair), .pair_value(pair_value), .disp(disp),
        .next_pc(next_pc), .direct_addr(direct_addr),
        .cpu_condition_register(cpu_condition_register), .branch_flags(branch_flags),
        .result(result), .result_we(result_we), .done(done), .dest_conflict(dest_conflict),
        .pair_ok(pair_ok), .work_pair_ok(work_pair_ok), .direct_ok(direct_ok),
        .short_index_addr(short_index_addr), .branch_target(branch_target));

    csfa_seq_model i_csfa_seq_model (.clk_sys(clk_sys), .op_valid(op_valid), .op(op),
        .dst_value(dst_value), .src_value(src_value), .dst_addr(dst_addr),
        .load_valid(load_valid), .load_addr(load_addr), .load_data(load_data));

    task automatic results();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask

    // The software nibble stays at the value loaded into the flag register, so every op also guards it.
    task automatic run_op(input csfa_op_e code, input logic [7:0] d, input logic [7:0] s,
                          input logic [7:0] a, input logic [7:0] res, input logic [3:0] up,
                          input logic we);
        i_csfa_seq_model.do_op(code, d, s, a);
        chk({15'h0000, done}, 16'h0001);
        chk({15'h0000, dest_conflict}, {15'h0000, a == CSFA_FLAGS_ADDR});
        if (a != CSFA_FLAGS_ADDR) chk({15'h0000, result_we}, {15'h0000, we});
        if (we) chk({8'h00, result}, {8'h00, res});
        chk({8'h00, cpu_condition_register}, {8'h00, up, 4'hA});
        chk({12'h000, branch_flags}, {12'h000, up});
    endtask

    initial begin
        #20000;
        miscompares++;
        results();
    end

    initial begin
        rst_n = 1'b0;
        pair_addr = 8'h00;
        work_pair = 4'h0;
        pair_value = 16'h0000;
        disp = 8'h00;
        next_pc = 16'h0000;
        direct_addr = 16'h0000;
        repeat (10) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        chk({8'h00, cpu_condition_register}, {8'h00, CSFA_FLAGS_RESET});
        i_csfa_seq_model.do_load(8'h10, 8'h33);
        chk({8'h00, cpu_condition_register}, 16'h0000);
        i_csfa_seq_model.do_load(CSFA_FLAGS_ADDR, 8'h5A);
        chk({8'h00, cpu_condition_register}, 16'h005A);
        chk({12'h000, branch_flags}, 16'h0005);
        run_op(CSFA_OP_CARRY_SET, 8'h00, 8'h00, 8'h20, 8'h00, 4'hD, 1'b0);
        run_op(CSFA_OP_CARRY_INVERT, 8'h00, 8'h00, 8'h20, 8'h00, 4'h5, 1'b0);
        run_op(CSFA_OP_CARRY_INVERT, 8'h00, 8'h00, 8'h20, 8'h00, 4'hD, 1'b0);
        run_op(CSFA_OP_CARRY_CLEAR, 8'h00, 8'h00, 8'h20, 8'h00, 4'h5, 1'b0);
        run_op(CSFA_OP_ADD, 8'hFF, 8'h01, 8'h20, 8'h00, 4'hC, 1'b1);
        run_op(CSFA_OP_ADD, 8'h7F, 8'h01, 8'h20, 8'h80, 4'h3, 1'b1);
        run_op(CSFA_OP_SUB, 8'h00, 8'h01, 8'h20, 8'hFF, 4'hA, 1'b1);
        run_op(CSFA_OP_SUB, 8'h80, 8'h01, 8'h20, 8'h7F, 4'h1, 1'b1);
        run_op(CSFA_OP_AND, 8'hF0, 8'h0F, 8'h20, 8'h00, 4'h4, 1'b1);
        run_op(CSFA_OP_OR, 8'h80, 8'h01, 8'h20, 8'h81, 4'h2, 1'b1);
        run_op(CSFA_OP_CARRY_SET, 8'h00, 8'h00, 8'h20, 8'h00, 4'hA, 1'b0);
        run_op(CSFA_OP_ROT_LEFT_CARRY, 8'h80, 8'h00, 8'h20, 8'h01, 4'h9, 1'b1);
        run_op(CSFA_OP_ROT_RIGHT_CARRY, 8'h01, 8'h00, 8'h20, 8'h80, 4'hB, 1'b1);
        run_op(CSFA_OP_ARITH_SHIFT_RIGHT, 8'h01, 8'h00, 8'h20, 8'h00, 4'hC, 1'b1);
        run_op(CSFA_OP_ARITH_SHIFT_RIGHT, 8'h81, 8'h00, 8'h20, 8'hC0, 4'hA, 1'b1);
        run_op(CSFA_OP_MASK_TEST, 8'h0F, 8'hF0, 8'h20, 8'h00, 4'hC, 1'b0);
        run_op(CSFA_OP_INV_MASK_TEST, 8'h0F, 8'hF0, 8'h20, 8'h00, 4'hA, 1'b0);
        run_op(CSFA_OP_ADC, 8'h01, 8'h01, 8'h20, 8'h03, 4'h0, 1'b1);
        run_op(CSFA_OP_ADD, 8'hFF, 8'h01, CSFA_FLAGS_ADDR, 8'h00, 4'hC, 1'b0);
        i_csfa_seq_model.idle();
        pair_addr = 8'hFE;
        work_pair = 4'hE;
        direct_addr = 16'h1FFF;
        pair_value = 16'h1000;
        disp = 8'h80;
        next_pc = 16'h0100;
        @(posedge clk_sys);
        #1;
        chk({13'h0000, pair_ok, work_pair_ok, direct_ok}, 16'h0007);
        chk(short_index_addr, 16'h0F80);
        chk(branch_target, 16'h0080);
        pair_addr = 8'h03;
        work_pair = 4'hF;
        direct_addr = 16'h2000;
        disp = 8'h7F;
        @(posedge clk_sys);
        #1;
        chk({13'h0000, pair_ok, work_pair_ok, direct_ok}, 16'h0000);
        chk(short_index_addr, 16'h107F);
        chk(branch_target, 16'h017F);
        results();
    end
endmodule
